// file: rtl/pfrb_top.sv
// parity repair builder: xor accumulator, repair emitter, axi4-lite slave
// assumes inputs synchronous to clk; source words arrive in packet order
//
// Function
// - header and payload are xor of strings
// - string starts with first 16 header bits
// - then 16-bit length minus twelve, big-endian
// - then 32-bit timestamp, ssrc left out
// - then all octets after fixed header; code keeps only the first 64 payload words and drops the tail
// - top two result bits replaced by R,F
// - next bits: padding then extension recovery
// - four bits csrc count, then marker recovery
// - seven bits payload type recovery
// - sixteen bits length recovery
// - thirty-two bits timestamp recovery
// - lowest sequence number per stream as base
// - per stream mask if F=0, offsets if F=1
// - remaining result appended as repair payload
// - shorter strings zero-padded at the end
// - no parity build for retransmit packets
// - mask msb marks the base sequence number
`timescale 1ns/1ps
`default_nettype none

module pfrb_top
    import pfrb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    // source packet feed
    input  wire pfrb_src_t   src_in,
    output logic             src_ready,
    // repair stream
    output pfrb_rep_t        rep_out,
    input  wire logic        rep_ready,
    output logic [15:0]      rep_len,
    // axi4-lite slave
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;                 // two-stage release chain
    logic       rst_n;                      // synchronised reset for the rest

    // assert asynchronously, release on the second edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        pfrb_state_t                    st;       // accumulate or emit phase
        logic [6:0]                     widx;     // word index inside packet
        logic [31:0]                    acc_hdr;  // first 16 bits and length
        logic [31:0]                    acc_ts;   // timestamp parity
        logic [PAY_WORDS-1:0][31:0]     acc_pay;  // payload parity
        logic [NSTREAM-1:0]             seen;     // streams present in block
        logic [NSTREAM-1:0][15:0]       sn_base;  // lowest sequence seen
        logic [15:0]                    max_len;  // longest length minus twelve
        logic [6:0]                     eidx;     // payload word being sent
        logic                           in_rdy;
        logic                           drop;     // packet being discarded
        logic [1:0]                     ctrl;
        logic [NSTREAM-1:0][15:0]       prot;
        logic                           ovf;      // sticky: payload too long
        logic                           rrej;     // sticky: retransmit refused
        logic [15:0]                    blk_cnt;  // blocks emitted
        logic [15:0]                    len;      // repair length register
        logic                           awready;
        logic                           wready;
        logic [4:0]                     awaddr;
        logic [31:0]                    wdata;
        logic [3:0]                     wstrb;
        logic                           bvalid;
        logic [1:0]                     bresp;
        logic                           arready;
        logic                           rvalid;
        logic [31:0]                    rdata;
        logic [1:0]                     rresp;
        pfrb_rep_t                      outq;     // head of two-entry buffer
        pfrb_rep_t                      skid;     // second entry
    } pfrb_regs_t;

    pfrb_regs_t s_q;
    pfrb_regs_t s_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // keep only the bytes a final word really carries
    function automatic logic [31:0] pfrb_tail_mask(input logic [1:0] empty);
        case (empty)
            2'h1:    pfrb_tail_mask = 32'hFFFFFF00;
            2'h2:    pfrb_tail_mask = 32'hFFFF0000;
            2'h3:    pfrb_tail_mask = 32'hFF000000;
            default: pfrb_tail_mask = 32'hFFFFFFFF;
        endcase
    endfunction : pfrb_tail_mask

    // merge a write into a 16-bit field under byte strobes
    function automatic logic [15:0] pfrb_wr16(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
        pfrb_wr16 = old;
        if (strb[0]) begin
            pfrb_wr16[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            pfrb_wr16[15:8] = wd[15:8];
        end
    endfunction : pfrb_wr16

    // descriptor word: base, then mask or offsets
    function automatic logic [31:0] pfrb_desc(input logic [15:0] base,
                                              input logic [15:0] prot,
                                              input logic        fflag);
        if (fflag) begin
            pfrb_desc = {base, prot[15:8], prot[7:0]};
        end else begin
            // k=1 closes the short mask; msb is the base packet
            pfrb_desc = {base, 1'b1, prot[MASK_W-1:0]};
        end
    endfunction : pfrb_desc

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic              take;       // source word accepted
        logic              fin;        // final word of the block
        logic [9:0]        bytes;      // packet length in bytes
        logic [15:0]       plen;       // length minus fixed header
        logic [6:0]        pidx;       // payload word index
        logic              push;       // emitter offers a word
        pfrb_rep_t         item;       // word offered to buffer
        logic              room;       // buffer can take a word
        logic              pop;        // sink takes head word
        logic [6:0]        npay;       // payload words to send
        logic [31:0]       hdr;        // assembled first repair word
        logic              wr_go;
        logic              rd_go;
        logic [15:0]       stat;
        logic [1:0]        ev;         // sticky events this cycle
        take  = 1'b0;
        fin   = 1'b0;
        bytes = 10'h000;
        plen  = 16'h0000;
        pidx  = 7'h00;
        push  = 1'b0;
        item  = '0;
        wr_go = 1'b0;
        rd_go = 1'b0;
        stat  = 16'h0000;
        ev    = 2'h0;
        hdr   = 32'h00000000;
        s_d   = s_q;
        room  = !s_q.skid.valid;
        pop   = s_q.outq.valid && rep_ready;
        npay  = 7'((s_q.max_len + 16'h0003) >> 2);

        // -------- source absorption --------
        if (s_q.st == ST_ACC && s_q.in_rdy && src_in.valid) begin
            take = 1'b1;
        end
        if (take) begin
            // retransmit request: packets pass through unused
            if (s_q.widx == 7'h00 && s_q.ctrl[CTRL_R_BIT]) begin
                s_d.drop = 1'b1;
                {s_d.rrej, ev[1]} = 2'h3;
            end
            if (!(s_q.drop || (s_q.widx == 7'h00 && s_q.ctrl[CTRL_R_BIT]))) begin
                if (s_q.widx == 7'h00) begin
                    // version, flags, cc, marker, pt
                    s_d.acc_hdr[31:16] = s_q.acc_hdr[31:16] ^ src_in.data[31:16];
                    if (!s_q.seen[src_in.sid] ||
                        src_in.data[15:0] < s_q.sn_base[src_in.sid]) begin
                        s_d.sn_base[src_in.sid] = src_in.data[15:0];
                    end
                    s_d.seen[src_in.sid] = 1'b1;
                end else if (s_q.widx == 7'h01) begin
                    s_d.acc_ts = s_q.acc_ts ^ src_in.data;
                end else if (s_q.widx >= FIRST_PAY) begin
                    // ssrc word (index 2) falls through untouched
                    pidx = s_q.widx - FIRST_PAY;
                    if (pidx < 7'(PAY_WORDS)) begin
                        // words not written stay zero: end padding
                        s_d.acc_pay[pidx[PAY_IDX_W-1:0]] =
                            s_q.acc_pay[pidx[PAY_IDX_W-1:0]] ^
                            (src_in.data & (src_in.last ? pfrb_tail_mask(src_in.empty)
                                                        : 32'hFFFFFFFF));
                    end else begin
                        {s_d.ovf, ev[0]} = 2'h3;                    // overlong, tail lost
                    end
                end
                if (src_in.last) begin
                    bytes = {1'b0, s_q.widx, 2'b00} + 10'h004 - {8'h00, src_in.empty};
                    plen  = 16'(bytes - RTP_FIXED);
                    s_d.acc_hdr[15:0] = s_q.acc_hdr[15:0] ^ plen;
                    if (plen > s_q.max_len) begin
                        s_d.max_len = plen;
                    end
                end
            end
            if (src_in.last) begin
                s_d.widx = 7'h00;
                s_d.drop = 1'b0;
                // only build once some packet really entered
                fin = src_in.blk_end && (s_q.seen != '0 ||
                      !(s_q.drop || (s_q.widx == 7'h00 && s_q.ctrl[CTRL_R_BIT])));
            end else if (s_q.widx != 7'h7F) begin
                s_d.widx = s_q.widx + 7'h01;
            end
        end
        if (fin) begin
            s_d.st     = ST_HDR;
            s_d.in_rdy = 1'b0;
        end

        // -------- repair emission --------
        // r=0 always: this path only ever builds parity packets
        hdr = {1'b0, s_q.ctrl[CTRL_F_BIT], s_q.acc_hdr[29:28],
               s_q.acc_hdr[27:24], s_q.acc_hdr[23],
               s_q.acc_hdr[22:16],
               s_q.acc_hdr[15:0]};
        case (s_q.st)
            ST_ACC: begin
                push = 1'b0;
            end
            ST_HDR: begin
                push = 1'b1;
                item = '{valid: 1'b1, data: hdr, last: 1'b0};
                if (room) begin
                    s_d.st  = ST_TS;
                    s_d.len = FEC_FIXED + s_q.max_len +
                              (s_q.seen[0] ? DESC_BYTES : 16'h0000) +
                              (s_q.seen[1] ? DESC_BYTES : 16'h0000);
                end
            end
            ST_TS: begin
                push = 1'b1;
                item = '{valid: 1'b1, data: s_q.acc_ts,
                         last: (s_q.seen == '0) && (npay == 7'h00)};
                if (room) begin
                    s_d.st = ST_S0;
                end
            end
            ST_S0: begin
                push = s_q.seen[0];
                item = '{valid: 1'b1,
                         data: pfrb_desc(s_q.sn_base[0], s_q.prot[0], s_q.ctrl[CTRL_F_BIT]),
                         last: !s_q.seen[1] && (npay == 7'h00)};
                if (room || !s_q.seen[0]) begin
                    s_d.st = ST_S1;
                end
            end
            ST_S1: begin
                push = s_q.seen[1];
                item = '{valid: 1'b1,
                         data: pfrb_desc(s_q.sn_base[1], s_q.prot[1], s_q.ctrl[CTRL_F_BIT]),
                         last: (npay == 7'h00)};
                if (room || !s_q.seen[1]) begin
                    s_d.st   = ST_PAY;
                    s_d.eidx = 7'h00;
                end
            end
            ST_PAY: begin
                push = (s_q.eidx < npay);
                item = '{valid: 1'b1,
                         data: s_q.acc_pay[s_q.eidx[PAY_IDX_W-1:0]],
                         last: (s_q.eidx + 7'h01 == npay)};
                if (room && push) begin
                    s_d.eidx = s_q.eidx + 7'h01;
                end
                if (!push || (room && item.last)) begin
                    // block done: wipe so next strings pad with zero
                    s_d.st      = ST_ACC;
                    s_d.acc_hdr = '0;
                    s_d.acc_ts  = '0;
                    s_d.acc_pay = '0;
                    s_d.seen    = '0;
                    s_d.max_len = 16'h0000;
                    s_d.in_rdy  = 1'b1;
                    s_d.blk_cnt = s_q.blk_cnt + 16'h0001;
                end
            end
            default: begin
                s_d.st = ST_ACC;
            end
        endcase

        // -------- two-entry buffer --------
        // sink stall fills skid, which freezes the emitter
        push = push && room && (s_q.st != ST_ACC);
        if (!s_q.outq.valid || pop) begin
            if (s_q.skid.valid) begin
                s_d.outq = s_q.skid;
                s_d.skid = '0;
            end else begin
                s_d.outq = push ? item : '0;
            end
        end else if (push) begin
            s_d.skid = item;
        end

        // -------- axi4-lite write --------
        if (s_q.awready && s_axi_awvalid) begin
            s_d.awready = 1'b0;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.wready = 1'b0;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        wr_go = !s_q.awready && !s_q.wready && !s_q.bvalid;
        if (wr_go) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            case (s_q.awaddr)
                ADDR_CTRL: begin
                    if (s_q.wstrb[0]) begin
                        s_d.ctrl = s_q.wdata[1:0];
                    end
                end
                ADDR_PROT0: begin
                    s_d.prot[0] = pfrb_wr16(s_q.prot[0], s_q.wdata, s_q.wstrb);
                end
                ADDR_PROT1: begin
                    s_d.prot[1] = pfrb_wr16(s_q.prot[1], s_q.wdata, s_q.wstrb);
                end
                ADDR_STAT: begin
                    // write one clears; a same-cycle event wins
                    if (s_q.wstrb[0] && s_q.wdata[STAT_OVF] && !ev[0]) begin
                        s_d.ovf = 1'b0;
                    end
                    if (s_q.wstrb[0] && s_q.wdata[STAT_RREJ] && !ev[1]) begin
                        s_d.rrej = 1'b0;
                    end
                end
                ADDR_LEN: begin
                    s_d.bresp = RESP_OKAY;                          // read-only, ignored
                end
                default: begin
                    s_d.bresp = RESP_DECERR;
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // -------- axi4-lite read --------
        stat  = {s_q.blk_cnt[12:0], s_q.rrej, s_q.ovf, (s_q.st != ST_ACC)};
        rd_go = s_q.arready && s_axi_arvalid;
        if (rd_go) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:  s_d.rdata = {30'h00000000, s_q.ctrl};
                ADDR_PROT0: s_d.rdata = {16'h0000, s_q.prot[0]};
                ADDR_PROT1: s_d.rdata = {16'h0000, s_q.prot[1]};
                ADDR_STAT:  s_d.rdata = {16'h0000, stat};
                ADDR_LEN:   s_d.rdata = {16'h0000, s_q.len};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = RESP_DECERR;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.st      <= ST_ACC;
            s_q.in_rdy  <= 1'b1;
            s_q.ctrl    <= CTRL_RST;
            s_q.prot    <= {NSTREAM{PROT_RST}};
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------
    assign src_ready     = s_q.in_rdy;
    assign rep_out       = s_q.outq;
    assign rep_len       = s_q.len;
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rvalid  = s_q.rvalid;

endmodule : pfrb_top

`default_nettype wire

// file: inc/pfrb_pkg.sv
// parity repair builder: shared constants, register map and carrier types
// assumes a single 40 MHz clock domain and 32-bit big-endian stream words
package pfrb_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_CTRL   = 5'h00;    // flag variant, retransmit request
    localparam logic [4:0]  ADDR_PROT0  = 5'h04;    // stream 0 mask or offsets
    localparam logic [4:0]  ADDR_PROT1  = 5'h08;    // stream 1 mask or offsets
    localparam logic [4:0]  ADDR_STAT   = 5'h0C;    // status, w1c overflow
    localparam logic [4:0]  ADDR_LEN    = 5'h10;    // length of last repair packet
    localparam int          CTRL_F_BIT  = 0;        // 1 = offsets, 0 = bitmask
    localparam int          CTRL_R_BIT  = 1;        // retransmit request, blocks parity
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_OVF    = 1;
    localparam int          STAT_RREJ   = 2;
    localparam logic [1:0]  CTRL_RST    = 2'h0;
    localparam logic [15:0] PROT_RST    = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

    // ------------------------------------------------------------
    // packet geometry
    // ------------------------------------------------------------
    localparam int          NSTREAM     = 2;        // source streams per block
    localparam int          PAY_WORDS   = 64;       // repair payload capacity
    localparam int          PAY_IDX_W   = 6;
    localparam int          MASK_W      = 15;       // short bitmask form
    localparam logic [6:0]  FIRST_PAY   = 7'h03;    // word index after the ssrc
    localparam logic [9:0]  RTP_FIXED   = 10'h00C;  // fixed rtp header bytes
    localparam logic [15:0] FEC_FIXED   = 16'h0008; // repair header before descriptors
    localparam logic [15:0] DESC_BYTES  = 16'h0004; // one descriptor word per stream

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [31:0] data;     // big-endian: first byte in [31:24]
        logic        last;     // final word of a source packet
        logic [1:0]  empty;    // unused tail bytes on the final word
        logic        sid;      // source stream index
        logic        blk_end;  // this packet closes the source block
    } pfrb_src_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic        last;
    } pfrb_rep_t;

    typedef enum logic [2:0] {
        ST_ACC, ST_HDR, ST_TS, ST_S0, ST_S1, ST_PAY
    } pfrb_state_t;

endpackage : pfrb_pkg

// file: verification/pfrb_monitor.sv
// checker: repair stream hold, header R bit, register bus answer timing
// assumes it is bound into pfrb_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pfrb_monitor import pfrb_pkg::*; (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        src_ready,
    input wire pfrb_rep_t   rep_out,
    input wire logic        rep_ready,
    input wire logic [15:0] rep_len,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic hd_q; // next repair word is a header
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) hd_q <= 1'b1;
        else if (rep_out.valid && rep_ready) hd_q <= rep_out.last;
    sequence s_stall; rep_out.valid && !rep_ready; endsequence
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    a_rep_hold: assert property (
        s_stall |=> rep_out.valid && $stable(rep_out)) else $error("repair word lost");
    a_hdr_rbit: assert property (
        rep_out.valid && hd_q |-> !rep_out.data[31]) else $error("header R bit set");
    a_emit_after: assert property (
        rep_out.valid && hd_q |-> !src_ready) else $error("source open in emission");
    a_len_size: assert property (
        rep_out.valid |-> rep_len >= 16'h000C) else $error("repair length too small");
    a_b_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_r_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    a_rd_lat: assert property (
        s_rd_take |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
endmodule : pfrb_monitor
bind pfrb_top pfrb_monitor mon (.clk, .rstn, .src_ready, .rep_out, .rep_ready, .rep_len,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
    .s_axi_bready);
`default_nettype wire

// file: verification/pfrb_sink.sv
// partner: repair stream sink with random stalls, words kept in order
// assumes the bench reads and clears q between blocks
`timescale 1ns/1ps
`default_nettype none
module pfrb_sink import pfrb_pkg::*; (
    input wire logic      clk,
    input wire pfrb_rep_t rep_out,
    output logic          rep_ready
);
    logic [31:0] q[$]; // accepted words
    initial rep_ready = 1'b0;
    // stall about one cycle in three so the buffer fills
    always @(posedge clk) begin
        if (rep_out.valid && rep_ready) q.push_back(rep_out.data);
        rep_ready <= ($urandom % 3) != 0;
    end
endmodule : pfrb_sink
`default_nettype wire

// file: verification/tb.sv
// bench: random source blocks, repair words against an xor model
// assumes pfrb_top, pfrb_sink and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module tb import pfrb_pkg::*; ;
    logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wrd, bv, arr, rv, sr, rdy;
    logic [4:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [15:0] rl, pv[2];
    logic [1:0] br, rr;
    pfrb_src_t src = '0;
    pfrb_rep_t rep;
    int miscompares = 0, checks = 0, cyc = 0;
    pfrb_top uut (.clk(clk), .rstn(rstn), .src_in(src), .src_ready(sr), .rep_out(rep),
        .rep_ready(rdy), .rep_len(rl), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
    pfrb_sink snk (.clk(clk), .rep_out(rep), .rep_ready(rdy));
    initial forever #12.5 clk = ~clk;
    // hang guard
    always @(posedge clk) if (++cyc > 30000) begin miscompares++; report_and_stop(); end
    task automatic chk(input logic [31:0] e, g, input string n);
        checks++;
        if (g !== e) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (!bv);
        chk(RESP_OKAY, br, "bresp");
    endtask : wr
    task automatic rdr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        {ara, arv, rre} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
            {d, r} = {rd, rr};
        end while (!rv);
        rre <= 0;
    endtask : rdr
    task automatic put(input logic [31:0] d, input logic l, b, input logic [1:0] e, s);
        src <= '{1'b1, d, l, e, s[0], b};
        do @(posedge clk); while (!sr);
    endtask : put
    // one random block; rj means parity is refused and nothing may appear
    task automatic blk(input logic f, rj);
        logic [31:0] xh, xt, w;
        logic [3:0][31:0] xp;
        logic [15:0] sb[2], ml, ln;
        bit [1:0] sn;
        int n, e, np, x;
        logic s;
        {xh, xt, ml, xp, sn} = '0;
        np = 2 + $urandom % 3;
        for (int i = 0; i < np; i++) begin
            {s, n, e} = {1'($urandom), 1 + $urandom % 4, $urandom % 4};
            w = {2'h2, 30'($urandom)};
            ln = 16'(4 * n - e);
            xh ^= {w[31:16], ln};
            ml = ln > ml ? ln : ml;
            if (!sn[s] || w[15:0] < sb[s]) sb[s] = w[15:0];
            sn[s] = 1;
            put(w, 0, 0, 0, s);
            w = $urandom;
            xt ^= w;
            put(w, 0, 0, 0, s);
            put($urandom, 0, 0, 0, s);
            for (int k = 0; k < n; k++) begin
                w = k == n - 1 ? $urandom & (32'hFFFFFFFF << 8 * e) : $urandom;
                xp[k] ^= w;
                put(w, k == n - 1, k == n - 1 && i == np - 1, k == n - 1 ? e : 0, s);
            end
        end
        src.valid <= 0;
        x = rj ? 0 : 2 + sn[0] + sn[1] + (ml + 3) / 4;
        for (int k = 0; k < 300 && snk.q.size() < x; k++) @(posedge clk);
        repeat (20) @(posedge clk);
        chk(x, snk.q.size(), "count");
        if (!rj) begin
            chk({1'b0, f, xh[29:0]}, snk.q[0], "hdr");
            chk(xt, snk.q[1], "ts");
            x = 2;
            for (int t = 0; t < 2; t++) if (sn[t])
                chk({sb[t], pv[t] | {!f, 15'h0000}}, snk.q[x++], "desc");
            for (int k = 0; 4 * k < ml; k++) chk(xp[k], snk.q[x++], "pay");
            chk(8 + 4 * (sn[0] + sn[1]) + ml, rl, "len");
        end
        snk.q.delete();
    endtask : blk
    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        d = $urandom(32'h0AA2);
        repeat (16) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        rdr(5'h14, d, r);
        chk(RESP_DECERR, r, "decerr");
        for (int i = 0; i < 8; i++) begin
            pv = '{16'($urandom), 16'($urandom)};
            wr(ADDR_CTRL, i % 2);
            wr(ADDR_PROT0, pv[0]);
            wr(ADDR_PROT1, pv[1]);
            blk(i % 2, 0);
        end
        wr(ADDR_CTRL, 32'h2);
        blk(0, 1);
        rdr(ADDR_STAT, d, r);
        chk(1, d[STAT_RREJ], "rrej");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
